// File: logic/cop_pkg.sv
package cop_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 5;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int REMAIN_S    = 1800;
  localparam logic [19:0] REMAIN_MAX = 20'(REMAIN_S * 1000 / TICK_MS);
  localparam int PRE_LAG_MS  = 20;
  localparam int PRE_WIN_MS  = 20;
  localparam int PRE_LAG     = PRE_LAG_MS / TICK_MS;
  localparam int PRE_LEN     = PRE_WIN_MS / TICK_MS;
  localparam int HIST_DEPTH  = PRE_LAG + PRE_LEN;
  localparam int TRUE_RMS_HARM   = 32;

  // ---------------------------------------------------------------
  // Widths and scaling (currents in hundredths of nominal)
  // ---------------------------------------------------------------
  localparam int MAG_W   = 16;
  localparam int ISET_W  = 13;
  localparam int PROD_W  = 23;
  localparam int RATIO_W = 17;
  localparam logic [6:0] SCALE_100 = 7'h64;
  localparam logic [6:0] HYST_97   = 7'h61;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 17'h1E848;
  localparam logic [ISET_W-1:0]  ISET_MIN  = 13'h000A;
  localparam logic [ISET_W-1:0]  ISET_MAX  = 13'h1388;
  localparam logic [ISET_W-1:0]  ISET_RST  = 13'h0078;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_ISET   = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_MAXRAT = 6'h0C;
  localparam logic [5:0] OFS_EXPTIM = 6'h10;
  localparam logic [5:0] OFS_REMAIN = 6'h14;
  localparam logic [5:0] OFS_RATIO0 = 6'h18;
  localparam logic [5:0] OFS_PRE0   = 6'h24;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FSEL_LSB  = 4;
  localparam int CTRL_FEN_BIT   = 8;
  localparam int CTRL_MSEL_LSB  = 12;
  localparam int ST_COND_LSB    = 0;
  localparam int ST_BEHAV_LSB   = 4;
  localparam int ST_PICK_BIT    = 8;
  localparam int ST_START_BIT   = 9;
  localparam int ST_BLOCK_BIT   = 10;
  localparam int ST_TRIP_BIT    = 11;
  localparam int ST_PPH_LSB     = 12;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    COP_MODE_ON = 3'b001, COP_MODE_BLK = 3'b010, COP_MODE_TEST = 3'b011,
    COP_MODE_TBLK = 3'b100, COP_MODE_OFF = 3'b101
  } cop_mode_t;
  typedef enum logic [2:0] {
    COP_FRC_NORM = 3'b001, COP_FRC_START = 3'b010,
    COP_FRC_TRIP = 3'b011, COP_FRC_BLK = 3'b100
  } cop_force_t;
  typedef enum logic [1:0] {
    COP_COND_NORM = 2'b00, COP_COND_START = 2'b01,
    COP_COND_TRIP = 2'b10, COP_COND_BLK = 2'b11
  } cop_cond_t;
  typedef enum logic [1:0] {
    COP_MAG_RMS = 2'b01, COP_MAG_TRUE_RMS = 2'b10, COP_MAG_PP = 2'b11
  } cop_magsel_t;

  typedef struct packed {
    logic [2:0][MAG_W-1:0] rms;
    logic [2:0][MAG_W-1:0] true_rms;
    logic [2:0][MAG_W-1:0] peak_peak;
  } cop_meas_t;

  typedef struct packed {
    logic signed [19:0] expected;
    logic        [19:0] remaining;
  } cop_time_t;

endpackage

// File: logic/cop_top.sv
`timescale 1ns/1ps

// Overview of operation
// - Magnitude select: RMS, true RMS, peak-peak
// - True RMS input spans 32 harmonic components
// - Peak-peak value taken from raw samples
// - All nine magnitude inputs refresh every 5 ms
// - Pre-fault: 20 ms average, 20 ms before event
// - Per-phase ratio of magnitude to threshold
// - Pick-up when any phase exceeds threshold
// - Release only below fixed 97 percent
// - Threshold in 0.01 nominal, default 1.20
// - Start only while pick-up and not blocked, or when forced to Start or Trip
// - Mode On, Blocked, Test, Test/Blocked, Off
// - Forcing: Normal, Start, Trip, Blocked
// - Condition code Normal, Start, Trip, Blocked
// - Behaviour code mirrors the five modes
// - Static settings unaffected by group switching
// - Expected operating time in 5 ms steps
// - Remaining time to trip capped 1800 s
// - Highest ratio reported in hundredths
// - Blocking input sampled each processing cycle
// - Blocked pick-up flags blocked, clears start
module cop_top #(
  parameter int TICK_CYCLES = cop_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // Avalon-MM slave
  input  wire logic [5:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // Measurement chain and timing stage
  input  wire cop_pkg::cop_meas_t    meas,
  input  wire cop_pkg::cop_time_t    timing,
  input  wire logic                  block_in,
  input  wire logic                  trip_in,
  // Stage outputs
  output logic                       pickup,
  output logic                       start,
  output logic                       blocked,
  output logic                       trip,
  output logic [cop_pkg::MAG_W-1:0]  max_mag
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic rst_ok = rst_s2_reg;

  // ---------------------------------------------------------------
  // Processing tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  wire  logic  tick = ce && (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) tick_cnt_reg <= 32'h0;
    else if (ce) tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
  end

  // ---------------------------------------------------------------
  // Static settings
  // ---------------------------------------------------------------
  cop_pkg::cop_mode_t   mode_reg;
  cop_pkg::cop_force_t  fsel_reg;
  cop_pkg::cop_magsel_t msel_reg;
  logic                 fen_reg;
  logic [cop_pkg::ISET_W-1:0] iset_reg;
  logic                 waitreq_reg;
  wire logic wr_go = ce && write && !waitreq_reg;
  wire logic [2:0] wmode = writedata[cop_pkg::CTRL_MODE_LSB +: 3];
  wire logic [2:0] wfsel = writedata[cop_pkg::CTRL_FSEL_LSB +: 3];
  wire logic [1:0] wmsel = writedata[cop_pkg::CTRL_MSEL_LSB +: 2];
  wire logic [cop_pkg::ISET_W-1:0] wiset = writedata[cop_pkg::ISET_W-1:0];

  // Settings live outside any setting group; illegal codes are ignored
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      mode_reg <= cop_pkg::COP_MODE_ON;
      fsel_reg <= cop_pkg::COP_FRC_NORM;
      msel_reg <= cop_pkg::COP_MAG_RMS;
      fen_reg  <= 1'b0;
    end else if (wr_go && address == cop_pkg::OFS_CTRL) begin
      if (byteenable[0] && wmode >= 3'h1 && wmode <= 3'h5)
        mode_reg <= cop_pkg::cop_mode_t'(wmode);
      if (byteenable[0] && wfsel >= 3'h1 && wfsel <= 3'h4)
        fsel_reg <= cop_pkg::cop_force_t'(wfsel);
      if (byteenable[1])
        fen_reg <= writedata[cop_pkg::CTRL_FEN_BIT];
      if (byteenable[1] && wmsel != 2'h0)
        msel_reg <= cop_pkg::cop_magsel_t'(wmsel);
    end
  end

  // Threshold clamps to its legal range so the ratio never divides by 0
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) iset_reg <= cop_pkg::ISET_RST;
    else if (wr_go && address == cop_pkg::OFS_ISET && &byteenable[1:0]) begin
      if (wiset < cop_pkg::ISET_MIN) iset_reg <= cop_pkg::ISET_MIN;
      else if (wiset > cop_pkg::ISET_MAX) iset_reg <= cop_pkg::ISET_MAX;
      else iset_reg <= wiset;
    end
  end

  // ---------------------------------------------------------------
  // Magnitude selection and comparison
  // ---------------------------------------------------------------
  logic [2:0][cop_pkg::MAG_W-1:0] sel;
  logic [2:0][cop_pkg::MAG_W-1:0] mag_reg;
  logic [2:0]                     pick_reg, pick_next;
  logic [cop_pkg::PROD_W-1:0]     rel_lim;
  assign rel_lim = cop_pkg::PROD_W'(iset_reg)
                   * cop_pkg::PROD_W'(cop_pkg::HYST_97);

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      unique case (msel_reg)
        cop_pkg::COP_MAG_TRUE_RMS: sel[p] = meas.true_rms[p];
        cop_pkg::COP_MAG_PP:   sel[p] = meas.peak_peak[p];
        default:               sel[p] = meas.rms[p];
      endcase
      if (mode_reg == cop_pkg::COP_MODE_OFF)
        pick_next[p] = 1'b0;
      else if (sel[p] > cop_pkg::MAG_W'(iset_reg))
        pick_next[p] = 1'b1;
      else if (cop_pkg::PROD_W'(sel[p]) * cop_pkg::PROD_W'(cop_pkg::SCALE_100)
               < rel_lim)
        pick_next[p] = 1'b0;
      else
        pick_next[p] = pick_reg[p];
    end
  end

  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      mag_reg  <= '0;
      pick_reg <= 3'h0;
    end else if (tick) begin
      mag_reg  <= sel;
      pick_reg <= pick_next;
    end
  end

  // ---------------------------------------------------------------
  // Ratios
  // ---------------------------------------------------------------
  function automatic logic [cop_pkg::RATIO_W-1:0] ratio_of(
    input logic [cop_pkg::MAG_W-1:0]  m,
    input logic [cop_pkg::ISET_W-1:0] s
  );
    logic [cop_pkg::PROD_W-1:0] q;
    q = (cop_pkg::PROD_W'(m) * cop_pkg::PROD_W'(cop_pkg::SCALE_100))
        / cop_pkg::PROD_W'(s);
    if (q > cop_pkg::PROD_W'(cop_pkg::RATIO_MAX)) return cop_pkg::RATIO_MAX;
    return q[cop_pkg::RATIO_W-1:0];
  endfunction

  logic [2:0][cop_pkg::RATIO_W-1:0] ratio_reg;
  logic [cop_pkg::RATIO_W-1:0]      max_ratio_reg;
  logic [cop_pkg::MAG_W-1:0]        max_mag_reg;
  logic [cop_pkg::MAG_W-1:0]        top_mag;
  always_comb begin
    top_mag = mag_reg[0];
    for (int p = 1; p < 3; p++)
      if (mag_reg[p] > top_mag) top_mag = mag_reg[p];
  end

  // Dividers are combinational; the result is registered every cycle with ce high
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      ratio_reg     <= '0;
      max_ratio_reg <= '0;
      max_mag_reg   <= '0;
    end else if (ce) begin
      for (int p = 0; p < 3; p++)
        ratio_reg[p] <= ratio_of(mag_reg[p], iset_reg);
      max_ratio_reg <= ratio_of(top_mag, iset_reg);
      max_mag_reg   <= top_mag;
    end
  end

  // ---------------------------------------------------------------
  // Blocking, start, forcing, condition
  // ---------------------------------------------------------------
  logic blk_reg, pickup_reg, start_reg, blocked_reg, trip_reg;
  cop_pkg::cop_cond_t cond_reg;
  logic blk_now, pk_any, st_n, bl_n, tr_n;

  always_comb begin
    blk_now = block_in || mode_reg == cop_pkg::COP_MODE_BLK
              || mode_reg == cop_pkg::COP_MODE_TBLK;
    pk_any  = |pick_next;
    st_n    = pk_any && !blk_now;
    bl_n    = pk_any && blk_now;
    tr_n    = st_n && trip_in;
    if (fen_reg) begin
      unique case (fsel_reg)
        cop_pkg::COP_FRC_START: {st_n, bl_n, tr_n} = 3'b100;
        cop_pkg::COP_FRC_TRIP:  {st_n, bl_n, tr_n} = 3'b101;
        cop_pkg::COP_FRC_BLK:   {st_n, bl_n, tr_n} = 3'b010;
        default:                {st_n, bl_n, tr_n} = 3'b000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      blk_reg     <= 1'b0;
      pickup_reg  <= 1'b0;
      start_reg   <= 1'b0;
      blocked_reg <= 1'b0;
      trip_reg    <= 1'b0;
      cond_reg    <= cop_pkg::COP_COND_NORM;
    end else if (tick) begin
      blk_reg     <= blk_now;
      pickup_reg  <= pk_any;
      start_reg   <= st_n;
      blocked_reg <= bl_n;
      trip_reg    <= tr_n;
      if (tr_n)      cond_reg <= cop_pkg::COP_COND_TRIP;
      else if (st_n) cond_reg <= cop_pkg::COP_COND_START;
      else if (bl_n) cond_reg <= cop_pkg::COP_COND_BLK;
      else           cond_reg <= cop_pkg::COP_COND_NORM;
    end
  end

  // ---------------------------------------------------------------
  // Operating time reports
  // ---------------------------------------------------------------
  logic signed [19:0] exp_reg;
  logic        [19:0] remain_reg;
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      exp_reg    <= 20'sh0;
      remain_reg <= 20'h0;
    end else if (tick) begin
      if (timing.expected > $signed(cop_pkg::REMAIN_MAX))
        exp_reg <= $signed(cop_pkg::REMAIN_MAX);
      else if (timing.expected < -$signed(cop_pkg::REMAIN_MAX))
        exp_reg <= -$signed(cop_pkg::REMAIN_MAX);
      else
        exp_reg <= timing.expected;
      // Follows the start decision of this tick so it clears with start
      if (!st_n)
        remain_reg <= 20'h0;
      else if (timing.remaining > cop_pkg::REMAIN_MAX)
        remain_reg <= cop_pkg::REMAIN_MAX;
      else
        remain_reg <= timing.remaining;
    end
  end

  // ---------------------------------------------------------------
  // Pre-fault history
  // ---------------------------------------------------------------
  logic [cop_pkg::MAG_W-1:0] hist [3][cop_pkg::HIST_DEPTH];
  logic [2:0][cop_pkg::MAG_W-1:0] pre_reg;
  logic [2:0][cop_pkg::MAG_W+1:0] pre_sum;
  logic start_q_reg, trip_q_reg;
  wire logic event_rise = (start_reg && !start_q_reg)
                          || (trip_reg && !trip_q_reg);

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pre_sum[p] = '0;
      for (int i = cop_pkg::PRE_LAG; i < cop_pkg::HIST_DEPTH; i++)
        pre_sum[p] = pre_sum[p] + (cop_pkg::MAG_W+2)'(hist[p][i]);
    end
  end

  // History shifts on the tick that also updates the outputs, so on
  // an event entry 0 holds the sample taken on the event tick itself
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      for (int p = 0; p < 3; p++)
        for (int i = 0; i < cop_pkg::HIST_DEPTH; i++)
          hist[p][i] <= '0;
    end else if (tick) begin
      for (int p = 0; p < 3; p++) begin
        hist[p][0] <= sel[p];
        for (int i = 1; i < cop_pkg::HIST_DEPTH; i++)
          hist[p][i] <= hist[p][i-1];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      start_q_reg <= 1'b0;
      trip_q_reg  <= 1'b0;
      pre_reg     <= '0;
    end else if (ce) begin
      start_q_reg <= start_reg;
      trip_q_reg  <= trip_reg;
      if (event_rise)
        for (int p = 0; p < 3; p++)
          pre_reg[p] <= pre_sum[p][cop_pkg::MAG_W+1:2];
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait state per access
  // ---------------------------------------------------------------
  logic [31:0] rd_reg;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (address)
      cop_pkg::OFS_CTRL: begin
        rd_mux[cop_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
        rd_mux[cop_pkg::CTRL_FSEL_LSB +: 3] = fsel_reg;
        rd_mux[cop_pkg::CTRL_FEN_BIT]       = fen_reg;
        rd_mux[cop_pkg::CTRL_MSEL_LSB +: 2] = msel_reg;
      end
      cop_pkg::OFS_ISET:   rd_mux = 32'(iset_reg);
      cop_pkg::OFS_STATUS: begin
        rd_mux[cop_pkg::ST_COND_LSB +: 2]  = cond_reg;
        rd_mux[cop_pkg::ST_BEHAV_LSB +: 3] = mode_reg;
        rd_mux[cop_pkg::ST_PICK_BIT]       = pickup_reg;
        rd_mux[cop_pkg::ST_START_BIT]      = start_reg;
        rd_mux[cop_pkg::ST_BLOCK_BIT]      = blocked_reg;
        rd_mux[cop_pkg::ST_TRIP_BIT]       = trip_reg;
        rd_mux[cop_pkg::ST_PPH_LSB +: 3]   = pick_reg;
      end
      cop_pkg::OFS_MAXRAT: rd_mux = 32'(max_ratio_reg);
      cop_pkg::OFS_EXPTIM: rd_mux = 32'(exp_reg);
      cop_pkg::OFS_REMAIN: rd_mux = 32'(remain_reg);
      6'h18: rd_mux = 32'(ratio_reg[0]);
      6'h1C: rd_mux = 32'(ratio_reg[1]);
      6'h20: rd_mux = 32'(ratio_reg[2]);
      6'h24: rd_mux = 32'(pre_reg[0]);
      6'h28: rd_mux = 32'(pre_reg[1]);
      6'h2C: rd_mux = 32'(pre_reg[2]);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      waitreq_reg <= 1'b1;
      rd_reg      <= 32'h0;
    end else if (ce) begin
      if (waitreq_reg && (read || write)) begin
        waitreq_reg <= 1'b0;
        if (read) rd_reg <= rd_mux;
      end else begin
        waitreq_reg <= 1'b1;
      end
    end
  end

  assign readdata    = rd_reg;
  assign waitrequest = waitreq_reg;
  assign pickup      = pickup_reg;
  assign start       = start_reg;
  assign blocked     = blocked_reg;
  assign trip        = trip_reg;
  assign max_mag     = max_mag_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_ok);

  property p_sel_rms;
    tick && msel_reg == cop_pkg::COP_MAG_RMS
      |=> mag_reg[0] == $past(meas.rms[0]);
  endproperty
  a_sel_rms: assert property (p_sel_rms) else $error("rms not selected");

  property p_pick_set;
    tick && mode_reg != cop_pkg::COP_MODE_OFF
      && sel[1] > cop_pkg::MAG_W'(iset_reg) |=> pick_reg[1];
  endproperty
  a_pick_set: assert property (p_pick_set) else $error("no pick-up");

  property p_pick_hold;
    tick && pick_reg[2] && mode_reg != cop_pkg::COP_MODE_OFF
      && cop_pkg::PROD_W'(sel[2]) * cop_pkg::PROD_W'(cop_pkg::SCALE_100)
         >= rel_lim |=> pick_reg[2];
  endproperty
  a_pick_hold: assert property (p_pick_hold) else $error("early release");

  property p_hold_between;
    !tick |=> $stable(pick_reg) && $stable(start_reg);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("moved");

  property p_start_ok;
    start_reg && !fen_reg |-> pickup_reg && !blk_reg && !blocked_reg;
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("bad start");

  property p_blk_clears;
    tick && !fen_reg && blk_now && start_reg |=> !start_reg;
  endproperty
  a_blk_clears: assert property (p_blk_clears) else $error("start held");

  property p_cond_trip;
    trip_reg |-> cond_reg == cop_pkg::COP_COND_TRIP;
  endproperty
  a_cond_trip: assert property (p_cond_trip) else $error("cond wrong");

  property p_remain_cap;
    remain_reg <= cop_pkg::REMAIN_MAX
      && (start_reg || remain_reg == 20'h0);
  endproperty
  a_remain_cap: assert property (p_remain_cap) else $error("remain");

  property p_ratio_cap;
    max_ratio_reg <= cop_pkg::RATIO_MAX;
  endproperty
  a_ratio_cap: assert property (p_ratio_cap) else $error("ratio cap");

  property p_wait;
    ce && waitreq_reg && (read || write) |=> !waitreq_reg ##1 waitreq_reg;
  endproperty
  a_wait: assert property (p_wait) else $error("wait timing");

  c_start:   cover property (tick && st_n && !start_reg);
  c_blocked: cover property (tick && bl_n && start_reg);
  c_release: cover property (pick_reg[0] ##1 !pick_reg[0]);
  c_event:   cover property (event_rise);

endmodule

// File: tb/capacitor_overload_pickup_test.sv
`timescale 1ns/1ps
module capacitor_overload_pickup_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int TK = 20;
  localparam logic [15:0] HV [4] = '{16'h0078, 16'h0075, 16'h0074, 16'h0078};
  localparam logic        HP [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic               core_clk;
  logic               rst_n;
  logic [5:0]         address;
  logic               read;
  logic               write;
  logic [31:0]        writedata;
  logic [31:0]        readdata;
  logic               waitrequest;
  cop_pkg::cop_meas_t meas_set;
  cop_pkg::cop_meas_t meas;
  cop_pkg::cop_time_t timing;
  logic               block_in;
  logic               trip_in;
  logic               pickup;
  logic               start;
  logic               blocked;
  logic               trip;
  logic [15:0]        max_mag;
  logic [31:0]        rd;
  int                 miscompares;
  int                 comparisons;

  cop_meas_model u_meas (.core_clk(core_clk), .rst_n(rst_n),
    .meas_set(meas_set), .meas(meas));

  // Short tick keeps the run brief; settle and post-reset waits derive from TK
  cop_top #(.TICK_CYCLES(TK)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .ce(1'b1), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .meas(meas), .timing(timing),
    .block_in(block_in), .trip_in(trip_in), .pickup(pickup),
    .start(start), .blocked(blocked), .trip(trip), .max_mag(max_mag));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n == 100) miscompares++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask

  // Three ticks: change is seen at a tick whatever the phase
  task automatic settle();
    repeat (3 * TK) @(posedge core_clk);
  endtask

  task automatic set_mag(input int t, input logic [15:0] p1, p2, p3);
    cop_pkg::cop_meas_t m;
    m = '0;
    if (t == 0) m.rms = {p3, p2, p1};
    if (t == 1) m.true_rms = {p3, p2, p1};
    if (t == 2) m.peak_peak = {p3, p2, p1};
    meas_set <= m;
    settle();
  endtask

  function automatic logic [31:0] flags();
    return {28'h0, pickup, start, blocked, trip};
  endfunction

  task automatic end_of_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    block_in = 1'b0;
    trip_in = 1'b0;
    timing = {20'hFFFFB, 20'h00100};
    meas_set = '0;
    meas_set.rms[0] = 16'h0032;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10 * TK) @(posedge core_clk);
    rdc(cop_pkg::OFS_CTRL, 32'h00001011);
    rdc(cop_pkg::OFS_ISET, 32'h00000078);
    set_mag(0, 16'h0032, 16'h0079, 16'h0000);
    chk(flags(), 32'h0000000C);
    rdc(cop_pkg::OFS_STATUS, 32'h00002311);
    rdc(cop_pkg::OFS_PRE0, 32'h00000032);
    rdc(cop_pkg::OFS_REMAIN, 32'h00000100);
    rdc(cop_pkg::OFS_EXPTIM, 32'hFFFFFFFB);
    trip_in <= 1'b1;
    settle();
    chk(flags(), 32'h0000000D);
    rdc(cop_pkg::OFS_STATUS, 32'h00002B12);
    trip_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      set_mag(0, 16'h0032, HV[i], 16'h0000);
      chk({31'h0, pickup}, {31'h0, HP[i]});
    end
    set_mag(0, 16'h0032, 16'h00F0, 16'h0000);
    rdc(cop_pkg::OFS_MAXRAT, 32'h000000C8);
    rdc(cop_pkg::OFS_RATIO0 + 6'h04, 32'h000000C8);
    chk({16'h0, max_mag}, 32'h000000F0);
    block_in <= 1'b1;
    settle();
    chk(flags(), 32'h0000000A);
    rdc(cop_pkg::OFS_STATUS, 32'h00002513);
    block_in <= 1'b0;
    for (int m = 1; m <= 5; m++) begin
      wr(cop_pkg::OFS_CTRL, 32'h00001010 | 32'(m));
      settle();
      chk({30'h0, start, blocked},
          {30'h0, m == 1 || m == 3, m == 2 || m == 4});
      bus(1'b0, cop_pkg::OFS_STATUS, 32'h00000000);
      chk({29'h0, rd[6:4]}, 32'(m));
    end
    set_mag(0, 16'h0000, 16'h0000, 16'h0000);
    for (int f = 1; f <= 4; f++) begin
      wr(cop_pkg::OFS_CTRL, 32'h00001101 | (32'(f) << 4));
      settle();
      chk({29'h0, start, blocked, trip},
          {29'h0, f == 2 || f == 3, f == 4, f == 3});
    end
    for (int s = 1; s <= 3; s++) begin
      wr(cop_pkg::OFS_CTRL, 32'h00000011 | (32'(s) << 12));
      set_mag(s - 1, 16'h0000, 16'h0000, 16'h00C8);
      bus(1'b0, cop_pkg::OFS_STATUS, 32'h00000000);
      chk({28'h0, pickup, rd[14:12]}, 32'h0000000C);
    end
    // Selection code 0 is illegal: peak-peak must stay in force
    wr(cop_pkg::OFS_CTRL, 32'h00000011);
    settle();
    chk({31'h0, pickup}, 32'h00000001);
    rdc(cop_pkg::OFS_CTRL, 32'h00003011);
    wr(cop_pkg::OFS_CTRL, 32'h00001011);
    set_mag(0, 16'h0000, 16'h0000, 16'h0000);
    wr(cop_pkg::OFS_ISET, 32'h00000005);
    rdc(cop_pkg::OFS_ISET, 32'h0000000A);
    wr(cop_pkg::OFS_ISET, 32'h00001770);
    rdc(cop_pkg::OFS_ISET, 32'h00001388);
    wr(cop_pkg::OFS_ISET, 32'h00000078);
    wr(6'h3C, 32'hFFFFFFFF);
    rdc(6'h3C, 32'h00000000);
    wr(cop_pkg::OFS_STATUS, 32'hFFFFFFFF);
    rdc(cop_pkg::OFS_STATUS, 32'h00000010);
    end_of_test();
  end
endmodule

// File: tb/cop_meas_model.sv
`timescale 1ns/1ps
module cop_meas_model (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Magnitudes chosen by the bench
  input  wire cop_pkg::cop_meas_t meas_set,
  // Magnitudes seen by the stage
  output cop_pkg::cop_meas_t      meas
);
  // Refreshed every cycle, so every processing tick sees a whole, settled set;
  // true RMS and peak-peak arrive already computed from the samples
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas <= '0;
    end else begin
      meas <= meas_set;
    end
  end
endmodule
